// >>> core/ssar_map.svh
// constants of the serial audio receiver and its source: offsets, fields, timing
`ifndef SSAR_MAP_SVH
`define SSAR_MAP_SVH

// system clock
`define SSAR_CLK_PERIOD_NS 20
// longest gap between frames before the stream counts as stopped (two 8 kHz frames)
`define SSAR_FRAME_TIMEOUT_NS 250000
`define SSAR_WATCHDOG_CYCLES (`SSAR_FRAME_TIMEOUT_NS / `SSAR_CLK_PERIOD_NS)
// good slots in a row after an error; the next good slot lets samples flow again
`define SSAR_STABLE_SLOTS 4'h4
// legal slot lengths in bit clocks (32, 48, 64 per sample)
`define SSAR_SLOT_32 7'h10
`define SSAR_SLOT_48 7'h18
`define SSAR_SLOT_64 7'h20
// source bit clock: system clocks per half period
`define SSAR_SCLK_HALF_DIV 1

// source register byte offsets
`define SSAR_REG_CTRL 4'h0
`define SSAR_REG_LEFT 4'h4
`define SSAR_REG_RIGHT 4'h8
`define SSAR_REG_STATUS 4'hC
// control fields
`define SSAR_CTRL_EN 0
`define SSAR_CTRL_FMT_LSB 1
`define SSAR_CTRL_WID_LSB 3
`define SSAR_CTRL_RATIO_LSB 5
`define SSAR_CTRL_RESET 7'h00
// status fields
`define SSAR_STAT_RUN 16

`endif

// >>> core/ssar_pkg.sv
// types shared by the serial audio receiver and its source
`default_nettype none
package ssar_pkg;

  // framing of the serial stream
  typedef enum logic [1:0] {
    SSAR_FMT_STD = 2'h0,
    SSAR_FMT_LEFT_ALIGNED = 2'h1,
    SSAR_FMT_RIGHT_ALIGNED = 2'h2
  } ssar_fmt_t;

  // sample width
  typedef enum logic [1:0] {
    SSAR_W16 = 2'h0,
    SSAR_W20 = 2'h1,
    SSAR_W24 = 2'h2
  } ssar_width_t;

  // mono source selection
  typedef enum logic [1:0] {
    SSAR_MONO_MIX = 2'h0,
    SSAR_MONO_LEFT = 2'h1,
    SSAR_MONO_RIGHT = 2'h2
  } ssar_mono_t;

  // bit clocks per sample
  typedef enum logic [1:0] {
    SSAR_R32 = 2'h0,
    SSAR_R48 = 2'h1,
    SSAR_R64 = 2'h2
  } ssar_ratio_t;

  // number of sample bits for a width code
  function automatic logic [6:0] ssar_bits(input ssar_width_t w);
    case (w)
      SSAR_W16: ssar_bits = 7'h10;
      SSAR_W20: ssar_bits = 7'h14;
      default: ssar_bits = 7'h18;
    endcase
  endfunction

endpackage
`default_nettype wire

// >>> core/ssar_link_if.sv
// serial audio link between the source and the receiver
`timescale 1ns/1ps
`default_nettype none
interface ssar_link_if;
  logic serial_bit_clock; // bit clock, made by the source
  logic frame_channel_clock; // one cycle per sample period
  logic serial_audio_in; // serial data, msb first

  // audio source end
  modport source (
    output serial_bit_clock,
    output frame_channel_clock,
    output serial_audio_in
  );

  // receiver end
  modport device (
    input serial_bit_clock,
    input frame_channel_clock,
    input serial_audio_in
  );
endinterface
`default_nettype wire

// >>> core/ssar_source.sv
// audio source: avalon-mm register slave driving the serial audio link
`timescale 1ns/1ps
`default_nettype none
`include "ssar_map.svh"
module ssar_source
  import ssar_pkg::*;
#(
  parameter int unsigned SCLK_HALF_DIV = `SSAR_SCLK_HALF_DIV
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // avalon-mm slave
  input wire logic [3:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // link
  ssar_link_if.source link
);

  if (SCLK_HALF_DIV < 1 || SCLK_HALF_DIV > 255) begin : g_chk
    $error("ssar_source: SCLK_HALF_DIV out of range");
  end

  // ****************************************************
  // register slave
  // ****************************************************
  logic wait_q; // one wait state then answer
  logic [31:0] rdata_q;
  logic [6:0] ctrl_q; // enable, format, width, ratio
  logic [23:0] left_reg_q;
  logic [23:0] right_reg_q;
  logic [15:0] frames_q; // frames sent
  logic run_q; // frames are running
  logic req;
  assign req = read | write;

  // waitrequest: high first cycle, low the next
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
    end else begin
      wait_q <= ~(req & wait_q);
    end
  end

  // read data prepared during the wait cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && wait_q) begin
      case (address)
        `SSAR_REG_CTRL: rdata_q <= {25'h000_0000, ctrl_q};
        `SSAR_REG_LEFT: rdata_q <= {8'h00, left_reg_q};
        `SSAR_REG_RIGHT: rdata_q <= {8'h00, right_reg_q};
        `SSAR_REG_STATUS: rdata_q <= {15'h0000, run_q, frames_q};
        default: rdata_q <= 32'h0000_0000; // unmapped reads zero
      endcase
    end
  end

  // writes take effect when waitrequest is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= `SSAR_CTRL_RESET;
      left_reg_q <= 24'h00_0000;
      right_reg_q <= 24'h00_0000;
    end else if (write && !wait_q) begin
      case (address)
        `SSAR_REG_CTRL: ctrl_q <= writedata[6:0];
        `SSAR_REG_LEFT: left_reg_q <= writedata[23:0];
        `SSAR_REG_RIGHT: right_reg_q <= writedata[23:0];
        default: ;
      endcase
    end
  end

  assign readdata = rdata_q;
  assign waitrequest = wait_q;

  // ****************************************************
  // bit clock divider
  // ****************************************************
  logic [7:0] div_q;
  logic sclk_q;
  logic tick;
  logic fall;
  assign tick = (div_q == 8'(SCLK_HALF_DIV - 1));
  assign fall = tick & sclk_q;

  // clock runs while enabled or a frame is open, stops low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= 8'h00;
      sclk_q <= 1'b0;
    end else if (tick) begin
      div_q <= 8'h00;
      if (sclk_q || run_q || ctrl_q[`SSAR_CTRL_EN]) begin
        sclk_q <= ~sclk_q;
      end
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // ****************************************************
  // frame generator, data changes on falling bit clock
  // ****************************************************
  ssar_fmt_t fmt_q;
  ssar_width_t wid_q;
  ssar_ratio_t ratio_q;
  logic [23:0] lw_q, rw_q; // words of the current frame
  logic [6:0] pos_q; // bit position in frame
  logic lr_q, sd_q, prev_q;
  logic [6:0] last, npos, half, j, k, wb, lead;
  logic nleft, lj_bit, start;
  ssar_fmt_t nfmt;
  ssar_width_t nwid;
  ssar_ratio_t nratio;
  logic [23:0] word;

  always_comb begin
    unique case (ratio_q)
      SSAR_R32: last = 7'h1F;
      SSAR_R48: last = 7'h2F;
      default: last = 7'h3F;
    endcase
    start = !run_q || pos_q == last;
    npos = start ? 7'h00 : pos_q + 7'h01;
    nfmt = start ? ssar_fmt_t'(ctrl_q[2:1]) : fmt_q;
    nwid = start ? ssar_width_t'(ctrl_q[4:3]) : wid_q;
    nratio = start ? ssar_ratio_t'(ctrl_q[6:5]) : ratio_q;
    unique case (nratio)
      SSAR_R32: half = 7'h10;
      SSAR_R48: half = 7'h18;
      default: half = 7'h20;
    endcase
    wb = ssar_bits(nwid);
    nleft = npos < half;
    j = nleft ? npos : npos - half;
    word = nleft ? (start ? left_reg_q : lw_q) : (start ? right_reg_q : rw_q);
    lead = (half > wb) ? half - wb : 7'h00;
    // right aligned: leading slot bits are padding, lsb ends the slot
    k = (nfmt == SSAR_FMT_RIGHT_ALIGNED) ? j - lead : j;
    if (nfmt == SSAR_FMT_RIGHT_ALIGNED && j < lead) begin
      lj_bit = 1'b0;
    end else if (k < wb) begin
      lj_bit = word[5'(7'd23 - k)];
    end else begin
      lj_bit = 1'b0;
    end
  end

  // outputs move on the falling edge so they are steady at the rising one
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q <= 7'h00;
      run_q <= 1'b0;
      fmt_q <= SSAR_FMT_STD;
      wid_q <= SSAR_W16;
      ratio_q <= SSAR_R32;
      lw_q <= 24'h00_0000;
      rw_q <= 24'h00_0000;
      lr_q <= 1'b0;
      sd_q <= 1'b0;
      prev_q <= 1'b0;
      frames_q <= 16'h0000;
    end else if (fall) begin
      if (start) begin
        // one frame per sample period, config and words latched per frame
        run_q <= ctrl_q[`SSAR_CTRL_EN];
        fmt_q <= nfmt;
        wid_q <= nwid;
        ratio_q <= nratio;
        lw_q <= left_reg_q;
        rw_q <= right_reg_q;
        if (run_q) begin
          frames_q <= frames_q + 16'h0001;
        end
      end
      pos_q <= npos;
      prev_q <= lj_bit;
      if (nfmt == SSAR_FMT_STD) begin
        lr_q <= ~nleft;
        sd_q <= prev_q;
      end else begin
        lr_q <= nleft;
        sd_q <= lj_bit;
      end
    end
  end

  assign link.serial_bit_clock = sclk_q;
  assign link.frame_channel_clock = lr_q;
  assign link.serial_audio_in = sd_q;

endmodule
`default_nettype wire

// >>> core/ssar_receiver.sv
// stereo serial audio receiver: link-side deserializer and system-side sample port
`timescale 1ns/1ps
`default_nettype none
`include "ssar_map.svh"
// Functional notes
// - accepts 16/20/24-bit, three framings, selectable
// - samples come only from serial data pin
// - bit clock 32, 48 or 64 per sample
// - standard framing: frame clock low means left
// - standard framing: data one bit after edge
// - msb first, sampled on rising bit clock
// - trailing bits beyond width are ignored
// - aligned framings: frame clock high means left
// - left aligned: msb with frame edge
// - right aligned 24-bit: data after eight bits at 64x, from slot start at 48x
// - right aligned: lsb in last slot bit
// - right aligned: leading padding bits ignored
// - samples are two's complement, sign first
// - output 24-bit words, short samples left-aligned
// - mono output selects left, right or mix
// - source gives one frame per sample
// - other bit clock ratios are clock errors
// - error mutes at once, resumes when stable
module ssar_receiver
  import ssar_pkg::*;
#(
  parameter int unsigned WATCHDOG_CYCLES = `SSAR_WATCHDOG_CYCLES
) (
  // system clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // serial link
  ssar_link_if.device link,
  // static configuration
  input wire ssar_fmt_t fmt,
  input wire ssar_width_t width,
  input wire ssar_mono_t mono_sel,
  // samples toward the audio processor
  output logic sample_valid,
  output logic [23:0] left_sample,
  output logic [23:0] right_sample,
  output logic [23:0] mono_sample,
  output logic clock_error
);

  if (WATCHDOG_CYCLES < 2 || WATCHDOG_CYCLES > 65535) begin : g_chk
    $error("ssar_receiver: WATCHDOG_CYCLES out of range");
  end

  // ****************************************************
  // link domain reset and configuration crossing
  // ****************************************************
  logic sclk;
  assign sclk = link.serial_bit_clock;
  logic [1:0] lrst_q; // reset release synchroniser
  logic lrst_n;
  assign lrst_n = lrst_q[1];

  // reset leaves the link domain on its own clock
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      lrst_q <= 2'b00;
    end else begin
      lrst_q <= {lrst_q[0], 1'b1};
    end
  end

  logic [3:0] cfg_s1_q, cfg_s2_q; // quasi-static config synchroniser
  ssar_fmt_t fmt_q; // active framing
  ssar_width_t wid_q; // active width

  // two flops: config is static, only changes need care
  always_ff @(posedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      cfg_s1_q <= 4'h0;
      cfg_s2_q <= 4'h0;
    end else begin
      cfg_s1_q <= {fmt, width};
      cfg_s2_q <= cfg_s1_q;
    end
  end

  // ****************************************************
  // capture and slot alignment
  // ****************************************************
  logic lr_q, lr_d_q, dat_q; // pins caught on rising edge
  logic eff_q; // slot marker, high for left
  logic eff, edge_now, bit_in;
  logic [6:0] cnt_q, pos, wbits;

  // pins are synchronous to the bit clock, one capture flop each
  always_ff @(posedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      lr_q <= 1'b0;
      lr_d_q <= 1'b0;
      dat_q <= 1'b0;
      eff_q <= 1'b0;
      cnt_q <= 7'h00;
    end else begin
      lr_q <= link.frame_channel_clock;
      lr_d_q <= lr_q;
      dat_q <= link.serial_audio_in;
      eff_q <= eff;
      cnt_q <= pos;
    end
  end

  // standard framing: delaying the frame clock one bit makes it left aligned
  always_comb begin
    bit_in = dat_q;
    if (fmt_q == SSAR_FMT_STD) begin
      eff = ~lr_d_q;
    end else begin
      eff = lr_q;
    end
    edge_now = eff ^ eff_q;
    pos = edge_now ? 7'h00 : cnt_q + 7'h01;
    wbits = ssar_bits(wid_q);
  end

  // ****************************************************
  // deserializer
  // ****************************************************
  logic [23:0] sh_q; // incoming bits, newest at bit 0
  logic [23:0] shn;
  logic done, done_left;
  logic [23:0] raw, word;
  logic ra;
  assign ra = (fmt_q == SSAR_FMT_RIGHT_ALIGNED);
  assign shn = {sh_q[22:0], bit_in};

  always_comb begin
    if (ra) begin
      done = edge_now;
      done_left = eff_q;
      raw = sh_q; // last bits of the slot just ended
    end else begin
      done = (pos == wbits - 7'h01);
      done_left = eff;
      raw = shn;
    end
    // left-align and clear the unused low bits, sign stays on top
    word = raw << (7'd24 - wbits);
  end

  // right aligned shifts every bit, the others stop after the width
  always_ff @(posedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      sh_q <= 24'h00_0000;
    end else if (ra || pos < wbits) begin
      sh_q <= shn;
    end
  end

  // ****************************************************
  // clock ratio check and resynchronisation
  // ****************************************************
  logic [6:0] len_q; // length of last slot
  logic [3:0] good_q; // good slots in a row
  logic err_q; // link error, muting
  logic [6:0] len;
  logic len_ok, cfg_chg;
  assign len = cnt_q + 7'h01;
  assign len_ok = (len == `SSAR_SLOT_32 || len == `SSAR_SLOT_48 || len == `SSAR_SLOT_64)
                  && len == len_q && len >= wbits;
  assign cfg_chg = cfg_s2_q != {fmt_q, wid_q};

  // each slot is measured, config swaps only where a left slot begins
  always_ff @(posedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      len_q <= 7'h00;
      good_q <= 4'h0;
      err_q <= 1'b1;
      fmt_q <= SSAR_FMT_STD;
      wid_q <= SSAR_W16;
    end else if (edge_now) begin
      len_q <= len;
      if (eff && cfg_chg) begin
        fmt_q <= ssar_fmt_t'(cfg_s2_q[3:2]);
        wid_q <= ssar_width_t'(cfg_s2_q[1:0]);
        good_q <= 4'h0;
        err_q <= 1'b1;
      end else if (!len_ok) begin
        good_q <= 4'h0;
        err_q <= 1'b1;
      end else if (good_q == `SSAR_STABLE_SLOTS) begin
        err_q <= 1'b0;
      end else begin
        good_q <= good_q + 4'h1;
      end
    end
  end

  // ****************************************************
  // frame assembly and hand-off toward the system clock
  // ****************************************************
  logic [23:0] lhold_q, xl_q, xr_q; // xl/xr stand a whole frame
  logic have_left_q, tgl_q;

  // a frame is sent once the right word follows a left word
  always_ff @(posedge sclk or negedge lrst_n) begin
    if (!lrst_n) begin
      lhold_q <= 24'h00_0000;
      have_left_q <= 1'b0;
      xl_q <= 24'h00_0000;
      xr_q <= 24'h00_0000;
      tgl_q <= 1'b0;
    end else if (done) begin
      if (done_left) begin
        lhold_q <= word;
        have_left_q <= 1'b1;
      end else begin
        have_left_q <= 1'b0;
        if (have_left_q && !err_q) begin
          xl_q <= lhold_q;
          xr_q <= word;
          tgl_q <= ~tgl_q;
        end
      end
    end
  end

  // ****************************************************
  // system clock side
  // ****************************************************
  logic tg_s1_q, tg_s2_q, tg_s3_q; // frame toggle synchroniser
  logic er_s1_q, er_s2_q; // error level synchroniser
  logic [15:0] wd_q; // cycles since last frame
  logic stalled, newf, bad;
  assign newf = tg_s2_q ^ tg_s3_q;
  assign stalled = (wd_q == 16'(WATCHDOG_CYCLES));
  assign bad = er_s2_q | stalled;

  // crossings into the system clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tg_s1_q <= 1'b0;
      tg_s2_q <= 1'b0;
      tg_s3_q <= 1'b0;
      er_s1_q <= 1'b1;
      er_s2_q <= 1'b1;
    end else begin
      tg_s1_q <= tgl_q;
      tg_s2_q <= tg_s1_q;
      tg_s3_q <= tg_s2_q;
      er_s1_q <= err_q;
      er_s2_q <= er_s1_q;
    end
  end

  // watchdog catches a bit clock that stopped
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wd_q <= 16'h0000;
    end else if (newf) begin
      wd_q <= 16'h0000;
    end else if (!stalled) begin
      wd_q <= wd_q + 16'h0001;
    end
  end

  logic [24:0] mix;
  logic [23:0] mono;
  assign mix = {xl_q[23], xl_q} + {xr_q[23], xr_q};

  // mono source pick
  always_comb begin
    unique case (mono_sel)
      SSAR_MONO_LEFT: mono = xl_q;
      SSAR_MONO_RIGHT: mono = xr_q;
      default: mono = mix[24:1]; // halved sum
    endcase
  end

  // errors zero the outputs at once and stop the stream
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sample_valid <= 1'b0;
      left_sample <= 24'h00_0000;
      right_sample <= 24'h00_0000;
      mono_sample <= 24'h00_0000;
      clock_error <= 1'b1;
    end else begin
      clock_error <= bad;
      sample_valid <= newf & ~bad;
      if (bad) begin
        left_sample <= 24'h00_0000;
        right_sample <= 24'h00_0000;
        mono_sample <= 24'h00_0000;
      end else if (newf) begin
        left_sample <= xl_q;
        right_sample <= xr_q;
        mono_sample <= mono;
      end
    end
  end

endmodule
`default_nettype wire

// >>> testbench/ssar_link_asserts.sv
// assertion checker for the serial audio link and the receiver outputs
`timescale 1ns/1ps
`default_nettype none
module ssar_link_asserts
  import ssar_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // link wires
  input wire logic serial_bit_clock,
  input wire logic frame_channel_clock,
  input wire logic serial_audio_in,
  // receiver configuration
  input wire ssar_width_t width,
  input wire ssar_mono_t mono_sel,
  // receiver outputs
  input wire logic sample_valid,
  input wire logic [23:0] left_sample,
  input wire logic [23:0] right_sample,
  input wire logic [23:0] mono_sample,
  input wire logic clock_error
);
  // ****************
  // helpers
  // ****************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic [24:0] mix_sum; // sign-extended sum of both channels
  assign mix_sum = {left_sample[23], left_sample} + {right_sample[23], right_sample};
  logic [7:0] width_age_q; // clocks since width last moved, saturates
  // frames decoded before the receiver applies a new width must not trip the width checks
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      width_age_q <= 8'h00;
    end else if ($changed(width)) begin
      width_age_q <= 8'h00;
    end else if (width_age_q != 8'hFF) begin
      width_age_q <= width_age_q + 8'h01;
    end
  end
  // ****************
  // properties
  // ****************
  a_valid_one_cycle: assert property (sample_valid |=> !sample_valid)
    else $error("sample_valid longer than one cycle");
  a_error_no_valid: assert property (clock_error |-> !sample_valid)
    else $error("sample delivered while muted");
  a_error_zeroes_out: assert property (
    clock_error && $past(clock_error) |-> (left_sample | right_sample | mono_sample) == 24'h00_0000)
    else $error("samples not cleared while muted");
  a_samples_stand: assert property (
    !sample_valid && !clock_error |-> $stable(left_sample) && $stable(right_sample))
    else $error("samples changed without a frame");
  // the mono word was picked with the selection standing at the edge that loaded it
  a_mono_left_pick: assert property (
    sample_valid && $past(mono_sel) == SSAR_MONO_LEFT |-> mono_sample == left_sample)
    else $error("mono left selection wrong");
  a_mono_right_pick: assert property (
    sample_valid && $past(mono_sel) == SSAR_MONO_RIGHT |-> mono_sample == right_sample)
    else $error("mono right selection wrong");
  a_mono_mix_half: assert property (
    sample_valid && $past(mono_sel) == SSAR_MONO_MIX |-> mono_sample == mix_sum[24:1])
    else $error("mono mix wrong");
  a_w16_low_clear: assert property (
    sample_valid && width_age_q == 8'hFF && width == SSAR_W16 |-> (left_sample[7:0] | right_sample[7:0]) == 8'h00)
    else $error("16-bit sample low bits set");
  a_w20_low_clear: assert property (
    sample_valid && width_age_q == 8'hFF && width == SSAR_W20 |-> (left_sample[3:0] | right_sample[3:0]) == 4'h0)
    else $error("20-bit sample low bits set");
  a_data_on_fall: assert property ($changed(serial_audio_in) |-> !serial_bit_clock)
    else $error("data moved while bit clock high");
  a_frame_on_fall: assert property ($changed(frame_channel_clock) |-> !serial_bit_clock)
    else $error("frame clock moved while bit clock high");
  // main scenarios reached
  c_mix_frame: cover property (sample_valid && mono_sel == SSAR_MONO_MIX);
  c_mute: cover property ($rose(clock_error));
  c_resume: cover property ($fell(clock_error));
endmodule
`default_nettype wire

// >>> testbench/test_stereo_serial_audio_receiver.sv
// self-checking bench: source registers send frames into the receiver
`timescale 1ns/1ps
`default_nettype none
`include "ssar_map.svh"
module test_stereo_serial_audio_receiver
  import ssar_pkg::*;
;
  // ****************
  // signals
  // ****************
  logic clk, rst_n; // system clock and reset
  logic [3:0] address; // avalon request
  logic read, write;
  logic [31:0] writedata, readdata;
  logic waitrequest;
  ssar_fmt_t fmt; // receiver configuration
  ssar_width_t width;
  ssar_mono_t mono_sel;
  logic sample_valid, clock_error; // receiver outputs
  logic [23:0] left_sample, right_sample, mono_sample;
  int num_errors, num_checks;
  ssar_link_if link ();
  // ****************
  // instances
  // ****************
  ssar_source u_ssar_source (.clk(clk), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .link(link));
  ssar_receiver #(.WATCHDOG_CYCLES(300)) u_ssar_receiver (.clk(clk), .rst_n(rst_n), .link(link), .fmt(fmt),
    .width(width), .mono_sel(mono_sel), .sample_valid(sample_valid), .left_sample(left_sample),
    .right_sample(right_sample), .mono_sample(mono_sample), .clock_error(clock_error));
  ssar_link_asserts u_ssar_link_asserts (.clk(clk), .rst_n(rst_n), .serial_bit_clock(link.serial_bit_clock),
    .frame_channel_clock(link.frame_channel_clock), .serial_audio_in(link.serial_audio_in), .width(width),
    .mono_sel(mono_sel), .sample_valid(sample_valid), .left_sample(left_sample), .right_sample(right_sample),
    .mono_sample(mono_sample), .clock_error(clock_error));
  // ****************
  // tasks
  // ****************
  // compare and count
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon cycle, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    q = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50) chk("waitrequest", 32'h0000_0001, 32'h0000_0000);
  endtask
  // bounded wait: sel 0 for a frame, 1 for the mute flag
  task automatic wait_for(input int sel, input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while ((sel == 0 ? sample_valid : clock_error) !== 1'b1 && n < lim);
    if (n >= lim) chk(sel == 0 ? "sample_valid" : "clock_error", 32'h0000_0000, 32'h0000_0001);
  endtask
  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // ****************
  // clock and watchdog
  // ****************
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #(20 * 100000);
    num_errors++;
    end_of_test();
  end
  // ****************
  // tests
  // ****************
  initial begin
    logic [31:0] q;
    logic [23:0] l, r, el, er, em, mask;
    logic [24:0] s;
    int i;
    rst_n = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 4'h0;
    writedata = 32'h0000_0000;
    fmt = SSAR_FMT_STD;
    width = SSAR_W16;
    mono_sel = SSAR_MONO_MIX;
    num_errors = 0;
    num_checks = 0;
    repeat (4) @(posedge clk);
    chk("mute in reset", {31'h0, clock_error}, 32'h0000_0001);
    rst_n <= 1'b1;
    bus(1'b0, `SSAR_REG_CTRL, 32'h0000_0000, q);
    chk("ctrl reset", q, 32'h0000_0000);
    bus(1'b0, 4'h1, 32'h0000_0000, q);
    chk("unmapped read", q, 32'h0000_0000);
    $display("test reset done");
    // every framing, ratio and fitting width
    i = 0;
    for (int f = 0; f < 3; f++) begin
      for (int ra = 0; ra < 3; ra++) begin
        for (int w = 0; w < 3; w++) begin
          if (16 + 4 * w <= 16 + 8 * ra || w == 0) begin
            l = 24'h9C_3A57 + i * 24'h05_1F33;
            r = 24'h41_E60B - i * 24'h03_2B19;
            r[0] = l[0];
            mask = (w == 0) ? 24'hFF_FF00 : (w == 1) ? 24'hFF_FFF0 : 24'hFF_FFFF;
            el = l & mask;
            er = r & mask;
            s = {el[23], el} + {er[23], er};
            em = (i % 3 == 0) ? s[24:1] : (i % 3 == 1) ? el : er;
            fmt <= ssar_fmt_t'(f);
            width <= ssar_width_t'(w);
            mono_sel <= ssar_mono_t'(i % 3);
            bus(1'b1, `SSAR_REG_LEFT, {8'h00, l}, q);
            bus(1'b1, `SSAR_REG_RIGHT, {8'h00, r}, q);
            bus(1'b1, `SSAR_REG_CTRL, 32'(1 + (f << 1) + (w << 3) + (ra << 5)), q);
            wait_for(0, 3000);
            wait_for(0, 3000);
            chk("left", {8'h00, left_sample}, {8'h00, el});
            chk("right", {8'h00, right_sample}, {8'h00, er});
            chk("mono", {8'h00, mono_sample}, {8'h00, em});
            bus(1'b0, `SSAR_REG_STATUS, 32'h0000_0000, q);
            chk("running", {31'h0, q[`SSAR_STAT_RUN]}, 32'h0000_0001);
            i++;
          end
        end
      end
    end
    $display("test framings done");
    // width larger than a 32x slot is a clock error
    width <= SSAR_W24;
    bus(1'b1, `SSAR_REG_CTRL, 32'h0000_0001, q);
    wait_for(1, 2000);
    chk("muted left", {8'h00, left_sample}, 32'h0000_0000);
    width <= SSAR_W16;
    wait_for(0, 3000);
    chk("resumed", {31'h0, clock_error}, 32'h0000_0000);
    $display("test clock error done");
    // stopped stream mutes the receiver
    bus(1'b1, `SSAR_REG_CTRL, 32'h0000_0000, q);
    wait_for(1, 2000);
    bus(1'b0, `SSAR_REG_STATUS, 32'h0000_0000, q);
    chk("stopped", {31'h0, q[`SSAR_STAT_RUN]}, 32'h0000_0000);
    $display("test stop done");
    end_of_test();
  end
endmodule
`default_nettype wire
